// [src/spr_map.svh]
// register offsets, bit positions and reset values of the slot power registers
`ifndef SPR_MAP_SVH
`define SPR_MAP_SVH

// ==========================================================================
// command byte offsets
`define SPR_ADDR_SLOT_B_CONTROL  8'h03
`define SPR_ADDR_SLOT_B_STATUS   8'h05
`define SPR_ADDR_SHARED_STATUS   8'h06
`define SPR_RESET_BYTE           8'h00
`define SPR_READ_UNMAPPED        8'h00

// ==========================================================================
// slot_b_control bit positions
`define SPR_CTL_AUX_EN           0
`define SPR_CTL_MAIN_EN          1
`define SPR_CTL_OVR_BLOCK        2
`define SPR_CTL_MAIN_GOOD        6
`define SPR_CTL_AUX_GOOD         7

// ==========================================================================
// slot_b_status bit positions
`define SPR_STS_3V3_OC           0
`define SPR_STS_12V_OC           2
`define SPR_STS_AUX_OC           4
`define SPR_STS_AUX_ON           5
`define SPR_STS_MAIN_ON          6
`define SPR_STS_TRIP             7

// ==========================================================================
// shared_status bit positions
`define SPR_SHR_OT               1
`define SPR_SHR_UV               2
`define SPR_SHR_MASK             3
`define SPR_SHR_GPI_A            4
`define SPR_SHR_GPI_B            5

// ==========================================================================
// sticky flag and trip latch indexes
`define SPR_FLG_3V3              0
`define SPR_FLG_12V              1
`define SPR_FLG_AUX              2
`define SPR_FLG_UV               3
`define SPR_FLG_OT               4
`define SPR_NUM_FLAGS            5
`define SPR_TRIP_MAIN            0
`define SPR_TRIP_AUX             1
`define SPR_NUM_TRIPS            2

`endif

// [src/spr_pkg.sv]
// types shared by the slot power register logic
`default_nettype none

package spr_pkg;

   // ==========================================================================
   // register access request, command byte style
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } spr_reg_req_t;

   // ==========================================================================
   // analog supply monitors of slot b and the die
   typedef struct packed {
      logic aux_good;
      logic main_good;
      logic main_uvlo;
      logic overtemp;
   } spr_supply_in_t;

   // ==========================================================================
   // overcurrent detector events
   typedef struct packed {
      logic aux_oc;
      logic oc_12v;
      logic oc_3v3;
   } spr_oc_in_t;

   // ==========================================================================
   // hot plug request pins
   typedef struct packed {
      logic slot_b_main_request;
      logic slot_b_aux_request;
   } spr_req_in_t;

endpackage : spr_pkg

`default_nettype wire

// [src/spr_w1c_flags.sv]
// sticky fault flags, set by hardware, cleared by writing one
`default_nettype none

module spr_w1c_flags
   import spr_pkg::*;
#(
   parameter int unsigned N = 1
) (
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst_n,
   input  wire logic [N-1:0] i_set,
   input  wire logic [N-1:0] i_clr,
   output logic      [N-1:0] o_flags
);

   // ==========================================================================
   // one flag per entry, set wins over clear
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_flag
         always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               o_flags[g] <= 1'b0;
            end else if (i_set[g]) begin
               o_flags[g] <= 1'b1;
            end else if (i_clr[g]) begin
               o_flags[g] <= 1'b0;
            end
         end
      end
   endgenerate

endmodule : spr_w1c_flags

`default_nettype wire

// [src/spr_trip_latch.sv]
// trip latches held until the matching request input goes low or kill is raised
`default_nettype none

module spr_trip_latch
   import spr_pkg::*;
#(
   parameter int unsigned N = 1
) (
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_kill,
   input  wire logic [N-1:0] i_set,
   input  wire logic [N-1:0] i_request,
   output logic      [N-1:0] o_trip
);

   // ==========================================================================
   // kill holds all latches clear, a new fault beats a release
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_trip
         always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               o_trip[g] <= 1'b0;
            end else if (i_kill) begin
               o_trip[g] <= 1'b0;
            end else if (i_set[g]) begin
               o_trip[g] <= 1'b1;
            end else if (!i_request[g]) begin
               o_trip[g] <= 1'b0;
            end
         end
      end
   endgenerate

endmodule : spr_trip_latch

`default_nettype wire

// [src/spr_slot_regs.sv]
// slot b control, slot b status and shared status register logic
`default_nettype none
`include "spr_map.svh"

module spr_slot_regs
   import spr_pkg::*;
(
   input  wire logic           i_sys_clk,
   input  wire logic           i_rst_n,
   input  wire spr_reg_req_t   i_reg,
   output logic [7:0]          o_reg_rdata,
   output logic                o_reg_rvalid,
   input  wire spr_supply_in_t i_supply,
   input  wire spr_oc_in_t     i_oc,
   input  wire spr_req_in_t    i_req,
   input  wire logic           i_slot_b_override_n,
   input  wire logic           i_serial_management_path,
   input  wire logic           i_slot_a_gen_input,
   input  wire logic           i_slot_b_gen_input,
   output logic                o_slot_b_main_enable,
   output logic                o_slot_b_aux_enable,
   output logic                o_slot_b_power_ok_oe,
   output logic                o_slot_b_trip_oe,
   output logic                o_alert_line_oe
);

   // ==========================================================================
   // declarations
   logic                      main_en_q;
   logic                      aux_en_q;
   logic                      ovr_block_q;
   logic                      mask_q;
   logic                      aux_good_q;
   logic                      main_good_q;
   logic                      gpi_a_q;
   logic                      gpi_b_q;
   logic [`SPR_NUM_FLAGS-1:0] flags;
   logic [`SPR_NUM_FLAGS-1:0] flag_set;
   logic [`SPR_NUM_FLAGS-1:0] flag_clr;
   logic [`SPR_NUM_TRIPS-1:0] trip;
   logic [`SPR_NUM_TRIPS-1:0] trip_set;
   logic [`SPR_NUM_TRIPS-1:0] trip_req;
   wire                       wr_ctl;
   wire                       wr_sts;
   wire                       wr_shr;
   wire                       main_oc;
   wire                       override_act;
   wire                       trip_any;
   wire                       main_on_d;
   wire                       aux_on_d;
   wire                       power_ok_oe_d;
   wire                       trip_oe_d;
   wire                       alert_d;
   wire [7:0]                 ctl_rd;
   wire [7:0]                 sts_rd;
   wire [7:0]                 shr_rd;
   wire [7:0]                 rd_mux;

   // ==========================================================================
   // address decode
   assign wr_ctl = i_reg.wr && (i_reg.addr == `SPR_ADDR_SLOT_B_CONTROL);
   assign wr_sts = i_reg.wr && (i_reg.addr == `SPR_ADDR_SLOT_B_STATUS);
   assign wr_shr = i_reg.wr && (i_reg.addr == `SPR_ADDR_SHARED_STATUS);

   // ==========================================================================
   // control bits, only writable fields are taken
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         main_en_q   <= 1'b0;
         aux_en_q    <= 1'b0;
         ovr_block_q <= 1'b0;
      end else begin
         if (wr_ctl) begin
            ovr_block_q <= i_reg.wdata[`SPR_CTL_OVR_BLOCK];
         end
         if (i_oc.oc_12v || i_oc.oc_3v3) begin
            main_en_q <= 1'b0;
         end else if (wr_ctl) begin
            main_en_q <= i_reg.wdata[`SPR_CTL_MAIN_EN];
         end
         if (i_oc.aux_oc) begin
            aux_en_q <= 1'b0;
         end else if (wr_ctl) begin
            aux_en_q <= i_reg.wdata[`SPR_CTL_AUX_EN];
         end
      end
   end

   // ==========================================================================
   // alert mask
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mask_q <= 1'b0;
      end else if (wr_shr) begin
         mask_q <= i_reg.wdata[`SPR_SHR_MASK];
      end
   end

   // ==========================================================================
   // sampled levels, power good never sees the override
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         aux_good_q  <= 1'b0;
         main_good_q <= 1'b0;
         gpi_a_q     <= 1'b0;
         gpi_b_q     <= 1'b0;
      end else begin
         aux_good_q  <= i_supply.aux_good;
         main_good_q <= i_supply.main_good;
         gpi_a_q     <= i_slot_a_gen_input;
         gpi_b_q     <= i_slot_b_gen_input;
      end
   end

   // ==========================================================================
   // sticky flags
   assign main_oc = i_oc.oc_12v | i_oc.oc_3v3;

   assign flag_set[`SPR_FLG_3V3] = i_oc.oc_3v3;
   assign flag_set[`SPR_FLG_12V] = i_oc.oc_12v;
   assign flag_set[`SPR_FLG_AUX] = i_oc.aux_oc;
   assign flag_set[`SPR_FLG_UV]  = i_supply.main_uvlo &
                                   (i_req.slot_b_main_request | main_en_q);
   assign flag_set[`SPR_FLG_OT]  = i_supply.overtemp;

   assign flag_clr[`SPR_FLG_3V3] = wr_sts & i_reg.wdata[`SPR_STS_3V3_OC];
   assign flag_clr[`SPR_FLG_12V] = wr_sts & i_reg.wdata[`SPR_STS_12V_OC];
   assign flag_clr[`SPR_FLG_AUX] = wr_sts & i_reg.wdata[`SPR_STS_AUX_OC];
   assign flag_clr[`SPR_FLG_UV]  = wr_shr & i_reg.wdata[`SPR_SHR_UV];
   assign flag_clr[`SPR_FLG_OT]  = wr_shr & i_reg.wdata[`SPR_SHR_OT];

   spr_w1c_flags #(
      .N (`SPR_NUM_FLAGS)
   ) u_flags (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .i_set     (flag_set),
      .i_clr     (flag_clr),
      .o_flags   (flags)
   );

   // ==========================================================================
   // trip latches, untouched by register access
   assign trip_set[`SPR_TRIP_MAIN] = main_oc;
   assign trip_set[`SPR_TRIP_AUX]  = i_oc.aux_oc;
   assign trip_req[`SPR_TRIP_MAIN] = i_req.slot_b_main_request;
   assign trip_req[`SPR_TRIP_AUX]  = i_req.slot_b_aux_request;

   spr_trip_latch #(
      .N (`SPR_NUM_TRIPS)
   ) u_trip (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .i_kill    (i_serial_management_path),
      .i_set     (trip_set),
      .i_request (trip_req),
      .o_trip    (trip)
   );

   assign trip_any = |trip;

   // ==========================================================================
   // supply switching and pins
   assign override_act  = ~i_slot_b_override_n & ~ovr_block_q;
   assign main_on_d     = override_act |
                          ((main_en_q | i_req.slot_b_main_request) &
                           ~trip[`SPR_TRIP_MAIN]);
   assign aux_on_d      = override_act |
                          ((aux_en_q | i_req.slot_b_aux_request) &
                           ~trip[`SPR_TRIP_AUX]);
   assign power_ok_oe_d = override_act |
                          ~(i_supply.aux_good & i_supply.main_good);
   assign trip_oe_d     = trip_any & ~override_act;
   assign alert_d       = (|flags) & ~mask_q;

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_slot_b_main_enable <= 1'b0;
         o_slot_b_aux_enable  <= 1'b0;
         o_slot_b_power_ok_oe <= 1'b1;
         o_slot_b_trip_oe     <= 1'b0;
         o_alert_line_oe      <= 1'b0;
      end else begin
         o_slot_b_main_enable <= main_on_d;
         o_slot_b_aux_enable  <= aux_on_d;
         o_slot_b_power_ok_oe <= power_ok_oe_d;
         o_slot_b_trip_oe     <= trip_oe_d;
         o_alert_line_oe      <= alert_d;
      end
   end

   // ==========================================================================
   // read data, reserved and undefined bits give zero
   assign ctl_rd = (8'(aux_good_q)  << `SPR_CTL_AUX_GOOD)  |
                   (8'(main_good_q) << `SPR_CTL_MAIN_GOOD) |
                   (8'(ovr_block_q) << `SPR_CTL_OVR_BLOCK) |
                   (8'(main_en_q)   << `SPR_CTL_MAIN_EN)   |
                   (8'(aux_en_q)    << `SPR_CTL_AUX_EN);

   assign sts_rd = (8'(trip_any)                << `SPR_STS_TRIP)    |
                   (8'(o_slot_b_main_enable)    << `SPR_STS_MAIN_ON) |
                   (8'(o_slot_b_aux_enable)     << `SPR_STS_AUX_ON)  |
                   (8'(flags[`SPR_FLG_AUX])     << `SPR_STS_AUX_OC)  |
                   (8'(flags[`SPR_FLG_12V])     << `SPR_STS_12V_OC)  |
                   (8'(flags[`SPR_FLG_3V3])     << `SPR_STS_3V3_OC);

   assign shr_rd = (8'(gpi_b_q)             << `SPR_SHR_GPI_B) |
                   (8'(gpi_a_q)             << `SPR_SHR_GPI_A) |
                   (8'(mask_q)              << `SPR_SHR_MASK)  |
                   (8'(flags[`SPR_FLG_UV])  << `SPR_SHR_UV)    |
                   (8'(flags[`SPR_FLG_OT])  << `SPR_SHR_OT);

   assign rd_mux = (i_reg.addr == `SPR_ADDR_SLOT_B_CONTROL) ? ctl_rd :
                   (i_reg.addr == `SPR_ADDR_SLOT_B_STATUS)  ? sts_rd :
                   (i_reg.addr == `SPR_ADDR_SHARED_STATUS)  ? shr_rd :
                   `SPR_READ_UNMAPPED;

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_reg_rdata  <= `SPR_RESET_BYTE;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg.rd;
         if (i_reg.rd) begin
            o_reg_rdata <= rd_mux;
         end
      end
   end

   // ==========================================================================
   // assertions
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);

   property p_main_enable_follows_bit;
      (wr_ctl && i_reg.wdata[`SPR_CTL_MAIN_EN] && !main_oc && i_slot_b_override_n
       && !trip[`SPR_TRIP_MAIN])
      ##1 (!main_oc && !trip[`SPR_TRIP_MAIN]) |=> o_slot_b_main_enable;
   endproperty
   a_main_enable_follows_bit: assert property (p_main_enable_follows_bit)
      else $error("main supply did not switch on after control write");

   property p_override_blocked;
      (ovr_block_q && !main_en_q && !i_req.slot_b_main_request
       && !i_slot_b_override_n) |=> !o_slot_b_main_enable;
   endproperty
   a_override_blocked: assert property (p_override_blocked)
      else $error("blocked override still switched main supply on");

   property p_power_good_bits;
      i_supply.aux_good && i_supply.main_good |=> (ctl_rd[`SPR_CTL_AUX_GOOD]
         && ctl_rd[`SPR_CTL_MAIN_GOOD]);
   endproperty
   a_power_good_bits: assert property (p_power_good_bits)
      else $error("power good bits do not follow supplies");

   property p_reserved_zero;
      ctl_rd[5:3] == 3'h0 && sts_rd[3] == 1'b0 && sts_rd[1] == 1'b0
      && shr_rd[7:6] == 2'h0 && shr_rd[0] == 1'b0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bit read as one");

   property p_power_ok_and;
      i_slot_b_override_n |=> (o_slot_b_power_ok_oe ==
         !($past(i_supply.aux_good) && $past(i_supply.main_good)));
   endproperty
   a_power_ok_and: assert property (p_power_ok_and)
      else $error("power ok pin is not the and of both goods");

   property p_override_releases;
      (!i_slot_b_override_n && !ovr_block_q) |=> (o_slot_b_power_ok_oe
         && !o_slot_b_trip_oe);
   endproperty
   a_override_releases: assert property (p_override_releases)
      else $error("override did not release power ok and trip pins");

   property p_trip_bit_pin;
      (trip_any && i_slot_b_override_n && !ovr_block_q) ##1 trip_any |->
         o_slot_b_trip_oe && sts_rd[`SPR_STS_TRIP];
   endproperty
   a_trip_bit_pin: assert property (p_trip_bit_pin)
      else $error("trip bit and trip pin disagree");

   property p_flag_set_wins;
      (i_oc.oc_3v3 && wr_sts && i_reg.wdata[`SPR_STS_3V3_OC])
      |=> sts_rd[`SPR_STS_3V3_OC];
   endproperty
   a_flag_set_wins: assert property (p_flag_set_wins)
      else $error("overcurrent event lost against a clear");

   property p_w1c_clears;
      (wr_sts && i_reg.wdata[`SPR_STS_12V_OC] && !i_oc.oc_12v)
      |=> !flags[`SPR_FLG_12V];
   endproperty
   a_w1c_clears: assert property (p_w1c_clears)
      else $error("write of one did not clear 12v flag");

   property p_trip_holds;
      (trip[`SPR_TRIP_MAIN] && i_req.slot_b_main_request
       && !i_serial_management_path) |=> trip[`SPR_TRIP_MAIN];
   endproperty
   a_trip_holds: assert property (p_trip_holds)
      else $error("main trip released while request still high");

   property p_serial_no_trip;
      i_serial_management_path [*2] |-> !trip_any ##1 !o_slot_b_trip_oe;
   endproperty
   a_serial_no_trip: assert property (p_serial_no_trip)
      else $error("trip active under serial control");

   property p_uv_needs_cause;
      (!flags[`SPR_FLG_UV] && !(i_req.slot_b_main_request || main_en_q))
      |=> !flags[`SPR_FLG_UV];
   endproperty
   a_uv_needs_cause: assert property (p_uv_needs_cause)
      else $error("undervoltage flag set without request or enable");

   property p_ot_sticky;
      flags[`SPR_FLG_OT] && !(wr_shr && i_reg.wdata[`SPR_SHR_OT])
      |=> flags[`SPR_FLG_OT];
   endproperty
   a_ot_sticky: assert property (p_ot_sticky)
      else $error("over-temperature flag dropped without a clear");

   property p_alert_masked;
      (mask_q ##1 mask_q) |-> !o_alert_line_oe;
   endproperty
   a_alert_masked: assert property (p_alert_masked)
      else $error("alert driven while masked");

   property p_alert_follows;
      (!mask_q && (|flags)) |=> o_alert_line_oe;
   endproperty
   a_alert_follows: assert property (p_alert_follows)
      else $error("alert not driven with unmasked flag set");

   property p_ro_write_ignored;
      (wr_ctl && $stable(i_supply.aux_good)) |=> $stable(ctl_rd[`SPR_CTL_AUX_GOOD]);
   endproperty
   a_ro_write_ignored: assert property (p_ro_write_ignored)
      else $error("write disturbed a read-only bit");

endmodule : spr_slot_regs

`default_nettype wire

// [tb/spr_host_model.sv]
// register bus host model issuing command byte requests
`default_nettype none

module spr_host_model
   import spr_pkg::*;
(
   input  wire logic       i_sys_clk,
   input  wire logic [7:0] i_reg_rdata,
   input  wire logic       i_reg_rvalid,
   output var spr_reg_req_t o_reg
);
   timeunit 1ns;
   timeprecision 1ns;

   initial o_reg = '0;

   // ==================
   // write: one request edge, flag clears ride on it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_sys_clk) o_reg <= '{1'b1, 1'b0, a, d};
      @(posedge i_sys_clk) o_reg <= '0;
   endtask : wr

   // read: data taken with the valid pulse
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_sys_clk) o_reg <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge i_sys_clk) o_reg <= '0;
      #1;
      d = i_reg_rvalid ? i_reg_rdata : 8'hXX;
   endtask : rd
endmodule : spr_host_model

`default_nettype wire

// [tb/slot_power_status_registers_bench.sv]
// self-checking bench of the slot power register logic
`default_nettype none

module slot_power_status_registers_bench
   import spr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct packed {logic [3:0] s; logic [7:0] a, w, e;} spr_row_t;
   logic           clk = 1'b0;
   logic           rst_n = 1'b0;
   spr_reg_req_t   reg_req;
   logic [7:0]     rdata, got;
   logic           rvalid, main_en, aux_en, pok_oe, trip_oe, alert_oe;
   spr_supply_in_t sup = '0;
   spr_oc_in_t     oc = '0;
   spr_req_in_t    req = '0;
   logic           ovr_n = 1'b1, smp = 1'b0, gpa = 1'b0, gpb = 1'b1;
   int             fails = 0, checks_done = 0, cycles = 0;
   localparam spr_row_t ROWS [8] = '{
      '{4'h0, 8'h03, 8'hFF, 8'h07}, '{4'hC, 8'h03, 8'h00, 8'hC0},
      '{4'h4, 8'h03, 8'h01, 8'h41}, '{4'h8, 8'h03, 8'h02, 8'h82},
      '{4'h0, 8'h06, 8'hFF, 8'h28}, '{4'h0, 8'h06, 8'h00, 8'h20},
      '{4'h0, 8'h07, 8'hFF, 8'h00}, '{4'h0, 8'h03, 8'h00, 8'h00}};

   always #20 clk = ~clk;

   spr_host_model host (.i_sys_clk(clk), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid),
      .o_reg(reg_req));

   spr_slot_regs dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_reg(reg_req),
      .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_supply(sup), .i_oc(oc),
      .i_req(req), .i_slot_b_override_n(ovr_n), .i_serial_management_path(smp),
      .i_slot_a_gen_input(gpa), .i_slot_b_gen_input(gpb),
      .o_slot_b_main_enable(main_en), .o_slot_b_aux_enable(aux_en),
      .o_slot_b_power_ok_oe(pok_oe), .o_slot_b_trip_oe(trip_oe),
      .o_alert_line_oe(alert_oe));

   // ==================
   // helpers
   task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : cmp8

   task automatic cmp1(input logic g, input logic e);
      cmp8({7'h00, g}, {7'h00, e});
   endtask : cmp1

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic print_verdict;
      if (fails == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : print_verdict

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         fails++;
         print_verdict();
      end
   end

   // ==================
   // main sequence
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      foreach (ROWS[i]) begin
         @(posedge clk) sup <= ROWS[i].s;
         host.wr(ROWS[i].a, ROWS[i].w);
         host.rd(ROWS[i].a, got);
         cmp8(got, ROWS[i].e);
      end
      @(posedge clk) sup <= 4'hC;
      tick(3);
      cmp1(pok_oe, 1'b0);
      @(posedge clk) ovr_n <= 1'b0;
      tick(3);
      cmp1(pok_oe, 1'b1);
      host.rd(8'h03, got);
      cmp8(got, 8'hC0);
      host.wr(8'h03, 8'h04);
      tick(3);
      cmp1(pok_oe, 1'b0);
      host.wr(8'h03, 8'h00);
      @(posedge clk) ovr_n <= 1'b1;
      @(posedge clk) req <= 2'h2;
      tick(3);
      cmp1(main_en, 1'b1);
      @(posedge clk) oc <= 3'h2;
      @(posedge clk) oc <= '0;
      tick(3);
      cmp1(trip_oe, 1'b1);
      cmp1(alert_oe, 1'b1);
      host.rd(8'h05, got);
      cmp8(got, 8'h84);
      host.wr(8'h05, 8'h04);
      tick(2);
      cmp1(alert_oe, 1'b0);
      cmp1(trip_oe, 1'b1);
      @(posedge clk) ovr_n <= 1'b0;
      tick(3);
      cmp1(trip_oe, 1'b0);
      host.rd(8'h05, got);
      cmp8(got, 8'hE0);
      @(posedge clk) ovr_n <= 1'b1;
      tick(3);
      cmp1(trip_oe, 1'b1);
      @(posedge clk) req <= '0;
      tick(3);
      cmp1(trip_oe, 1'b0);
      // serial control, requests stay grounded
      @(posedge clk) smp <= 1'b1;
      @(posedge clk) oc <= 3'h4;
      @(posedge clk) oc <= '0;
      tick(3);
      cmp1(trip_oe, 1'b0);
      host.rd(8'h05, got);
      cmp1(got[7], 1'b0);
      host.wr(8'h05, 8'hFF);
      @(posedge clk) smp <= 1'b0;
      host.wr(8'h03, 8'h02);
      @(posedge clk) sup <= 4'h2;
      @(posedge clk) sup <= 4'h0;
      tick(3);
      host.rd(8'h06, got);
      cmp8(got, 8'h24);
      cmp1(alert_oe, 1'b1);
      host.wr(8'h03, 8'h00);
      host.wr(8'h06, 8'h04);
      @(posedge clk) sup <= 4'h2;
      @(posedge clk) sup <= 4'h1;
      @(posedge clk) sup <= 4'h0;
      tick(3);
      host.rd(8'h06, got);
      cmp8(got, 8'h22);
      host.wr(8'h06, 8'h08);
      tick(2);
      cmp1(alert_oe, 1'b0);
      @(posedge clk) gpa <= 1'b1;
      @(posedge clk) gpb <= 1'b0;
      host.wr(8'h06, 8'h02);
      host.rd(8'h06, got);
      cmp8(got, 8'h10);
      // overcurrent event in the same cycle as its clear
      fork
         host.wr(8'h05, 8'h01);
         begin
            @(posedge clk) oc <= 3'h1;
            @(posedge clk) oc <= '0;
         end
      join
      host.rd(8'h05, got);
      cmp1(got[0], 1'b1);
      host.wr(8'h03, 8'h03);
      tick(2);
      cmp1(aux_en, 1'b1);
      @(posedge clk) rst_n <= 1'b0;
      tick(3);
      cmp1(main_en, 1'b0);
      cmp1(aux_en, 1'b0);
      cmp1(pok_oe, 1'b1);
      @(posedge clk) rst_n <= 1'b1;
      host.rd(8'h03, got);
      cmp8(got, 8'h00);
      host.rd(8'h05, got);
      cmp8(got, 8'h00);
      print_verdict();
   end
endmodule : slot_power_status_registers_bench

`default_nettype wire
